// File: design/ltl_pkg.sv
// ltl_pkg: constants for the light threshold limit register bank
// assumes a byte-wide register port from a two-wire serial front end
package ltl_pkg;
  localparam int          REG_W        = 16;
  localparam int          EXP_W        = 4;
  localparam int          MANT_W       = 12;
  localparam int          EXP_LSB      = 12;
  localparam int          POW_W        = MANT_W + 11;
  localparam logic [7:0]  ADDR_LOWER   = 8'h02;
  localparam logic [7:0]  ADDR_UPPER   = 8'h03;
  localparam logic [7:0]  ADDR_MAKER   = 8'h7E;
  localparam logic [15:0] LOWER_RESET  = 16'h0000;
  localparam logic [15:0] UPPER_RESET  = 16'hBFFF;
  localparam logic [3:0]  EXP_MAX      = 4'hB;
  // arbitrary neutral identification value
  localparam logic [15:0] MAKER_CODE   = 16'h4C53;
  localparam logic [1:0]  FC_ONE       = 2'h0;
  localparam logic [1:0]  FC_TWO       = 2'h1;
  localparam logic [1:0]  FC_FOUR      = 2'h2;
  localparam logic [3:0]  CNT_ONE      = 4'h1;
  localparam logic [3:0]  CNT_TWO      = 4'h2;
  localparam logic [3:0]  CNT_FOUR     = 4'h4;
  localparam logic [3:0]  CNT_EIGHT    = 4'h8;
  localparam logic [3:0]  CNT_ZERO     = 4'h0;
endpackage : ltl_pkg

// File: design/ltl_to_power.sv
// ltl_to_power: exponent/mantissa word to linear optical power code
// assumes combinational use inside the register bank clock domain
`timescale 1ns/1ps
module ltl_to_power (
  // word in
  input  wire logic [ltl_pkg::REG_W-1:0] word_i,
  // linear power, units of one lsb at exponent zero
  output logic      [ltl_pkg::POW_W-1:0] power_o
);
  import ltl_pkg::*;
  logic [EXP_W-1:0]  exp_w;
  logic [MANT_W-1:0] mant_w;
  always_comb begin
    exp_w  = word_i[REG_W-1:EXP_LSB];
    mant_w = word_i[MANT_W-1:0];
    // codes above the top range saturate to it
    if (exp_w > EXP_MAX) begin
      exp_w = EXP_MAX;
    end
    // common factor 1.2 dropped: ordering is unchanged
    power_o = POW_W'(mant_w) << exp_w;
  end
endmodule : ltl_to_power

// File: design/ltl_regs.sv
// ltl_regs: threshold registers, maker code and window comparison
// assumes a serial front end issuing byte reads/writes by register pointer
//
// Summary of operation
// - lower threshold at 02h, exponent 15-12, mantissa 11-0, resets to zero.
// - mantissa is unsigned straight binary from zero to full scale.
// - power equals 1.2 times two to the exponent times mantissa.
// - exponent codes 0 to 11, each step doubles lsb weight and full scale.
// - result and thresholds convert to power before any comparison.
// - upper threshold at 03h, same layout, resets to exponent Bh mantissa FFFh.
// - comparison uses the true result exponent, never the masked one.
// - the two thresholds bound the alert pin and both flags.
// - read-only maker code at 7Eh; writes are ignored.
// - under flag set after result below lower for fault count measurements.
// - fault count field 00,01,10,11 selects one, two, four, eight events.
`timescale 1ns/1ps
module ltl_regs (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      reset_n_i,
  // register port from serial front end
  input  wire logic [7:0]                reg_ptr_i,
  input  wire logic                      wr_byte_i,
  input  wire logic                      wr_first_i,
  input  wire logic [7:0]                wr_data_i,
  input  wire logic                      rd_byte_i,
  input  wire logic                      rd_first_i,
  output logic      [7:0]                rd_data_o,
  // measurement side
  input  wire logic                      result_valid_i,
  input  wire logic [ltl_pkg::REG_W-1:0] result_raw_i,
  input  wire logic [1:0]                fault_count_i,
  input  wire logic                      flag_clear_i,
  // comparison outputs
  output logic                           over_flag_o,
  output logic                           under_flag_o,
  output logic                           alert_o,
  output logic [ltl_pkg::REG_W-1:0]      lower_o,
  output logic [ltl_pkg::REG_W-1:0]      upper_o
);
  import ltl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register file: pointer decode, byte assembly and read snapshot
  logic [REG_W-1:0] lower_q;
  logic [REG_W-1:0] lower_d;
  logic [REG_W-1:0] upper_q;
  logic [REG_W-1:0] upper_d;
  logic [7:0]       wr_hold_q;
  logic [7:0]       wr_hold_d;
  logic [7:0]       rd_lo_q;
  logic [7:0]       rd_lo_d;
  logic [7:0]       rd_data_q;
  logic [7:0]       rd_data_d;
  logic [REG_W-1:0] sel_w;

  // unmapped pointers read as zero; the maker code has no storage at all
  always_comb begin
    if (reg_ptr_i == ADDR_LOWER) begin
      sel_w = lower_q;
    end else if (reg_ptr_i == ADDR_UPPER) begin
      sel_w = upper_q;
    end else if (reg_ptr_i == ADDR_MAKER) begin
      sel_w = MAKER_CODE;
    end else begin
      sel_w = '0;
    end
  end

  always_comb begin
    lower_d   = lower_q;
    upper_d   = upper_q;
    wr_hold_d = wr_hold_q;
    rd_lo_d   = rd_lo_q;
    rd_data_d = rd_data_q;
    // msb byte is held; the register updates whole on the lsb byte
    if (wr_byte_i && wr_first_i) begin
      wr_hold_d = wr_data_i;
    end else if (wr_byte_i) begin
      if (reg_ptr_i == ADDR_LOWER) begin
        lower_d = {wr_hold_q, wr_data_i};
      end else if (reg_ptr_i == ADDR_UPPER) begin
        upper_d = {wr_hold_q, wr_data_i};
      end
      // the maker code and unmapped pointers have no write path
    end
    // lsb snapshot at msb read keeps the 16-bit value coherent
    if (rd_byte_i && rd_first_i) begin
      rd_data_d = sel_w[REG_W-1:8];
      rd_lo_d   = sel_w[7:0];
    end else if (rd_byte_i) begin
      rd_data_d = rd_lo_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      lower_q   <= LOWER_RESET;
      upper_q   <= UPPER_RESET;
      wr_hold_q <= 8'h00;
      rd_lo_q   <= 8'h00;
      rd_data_q <= 8'h00;
    end else begin
      lower_q   <= lower_d;
      upper_q   <= upper_d;
      wr_hold_q <= wr_hold_d;
      rd_lo_q   <= rd_lo_d;
      rd_data_q <= rd_data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // linear power codes, so mixed exponents compare correctly
  logic [POW_W-1:0] res_pow_w;
  logic [POW_W-1:0] low_pow_w;
  logic [POW_W-1:0] up_pow_w;

  // raw result carries the true exponent, masking happens elsewhere
  ltl_to_power u_res (
    .word_i  (result_raw_i),
    .power_o (res_pow_w)
  );
  ltl_to_power u_low (
    .word_i  (lower_q),
    .power_o (low_pow_w)
  );
  ltl_to_power u_up (
    .word_i  (upper_q),
    .power_o (up_pow_w)
  );

  // fault count is a live level: a change applies from the next result
  logic [3:0] need_w;
  always_comb begin
    case (fault_count_i)
      FC_ONE:  need_w = CNT_ONE;
      FC_TWO:  need_w = CNT_TWO;
      FC_FOUR: need_w = CNT_FOUR;
      default: need_w = CNT_EIGHT;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // window comparison: run counters, sticky flags and alert
  logic [3:0] hi_cnt_q;
  logic [3:0] hi_cnt_d;
  logic [3:0] lo_cnt_q;
  logic [3:0] lo_cnt_d;
  logic       over_q;
  logic       over_d;
  logic       under_q;
  logic       under_d;
  logic       alert_q;
  logic       alert_d;
  logic       is_hi_w;
  logic       is_lo_w;

  always_comb begin
    is_hi_w  = res_pow_w > up_pow_w;
    is_lo_w  = res_pow_w < low_pow_w;
    hi_cnt_d = hi_cnt_q;
    lo_cnt_d = lo_cnt_q;
    over_d   = over_q;
    under_d  = under_q;
    // clear first so a same-cycle event wins
    if (flag_clear_i) begin
      over_d  = 1'b0;
      under_d = 1'b0;
    end
    if (result_valid_i) begin
      // counter saturates at need so long runs cannot wrap
      // a run still standing after a clear sets its flag again on the next result
      if (!is_hi_w) begin
        hi_cnt_d = CNT_ZERO;
      end else if (hi_cnt_q < need_w) begin
        hi_cnt_d = hi_cnt_q + CNT_ONE;
      end
      if (!is_lo_w) begin
        lo_cnt_d = CNT_ZERO;
      end else if (lo_cnt_q < need_w) begin
        lo_cnt_d = lo_cnt_q + CNT_ONE;
      end
      if (hi_cnt_d >= need_w) begin
        over_d = 1'b1;
      end
      if (lo_cnt_d >= need_w) begin
        under_d = 1'b1;
      end
    end
    // alert follows the next flag values, so it never lags them by a cycle
    alert_d = over_d | under_d;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      hi_cnt_q <= CNT_ZERO;
      lo_cnt_q <= CNT_ZERO;
      over_q   <= 1'b0;
      under_q  <= 1'b0;
      alert_q  <= 1'b0;
    end else begin
      hi_cnt_q <= hi_cnt_d;
      lo_cnt_q <= lo_cnt_d;
      over_q   <= over_d;
      under_q  <= under_d;
      alert_q  <= alert_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs come straight from the registers above
  assign rd_data_o    = rd_data_q;
  assign over_flag_o  = over_q;
  assign under_flag_o = under_q;
  assign alert_o      = alert_q;
  assign lower_o      = lower_q;
  assign upper_o      = upper_q;
endmodule : ltl_regs

// File: sim/ltl_host.sv
// ltl_host: byte-level register host in place of the serial front end
// assumes the bench clock; drives on falling edges, msb byte first
`timescale 1ns/1ps
module ltl_host (
  input  wire logic       clk_i,
  output logic      [7:0] ptr_o,
  output logic            wr_o,
  output logic            wf_o,
  output logic      [7:0] wd_o,
  output logic            rd_o,
  output logic            rf_o,
  input  wire logic [7:0] rd_data_i
);
  initial {ptr_o, wr_o, wf_o, wd_o, rd_o, rf_o} = '0;
  // released data shows the inverse, never a stale copy
  task automatic wr16(input logic [7:0] p, input logic [15:0] v);
    @(negedge clk_i) {ptr_o, wr_o, wf_o, wd_o} = {p, 2'b11, v[15:8]};
    @(negedge clk_i) {wf_o, wd_o} = {1'b0, v[7:0]};
    @(negedge clk_i) {wr_o, wd_o} = {1'b0, ~v[7:0]};
  endtask : wr16
  task automatic rd16(input logic [7:0] p, output logic [15:0] v);
    @(negedge clk_i) {ptr_o, rd_o, rf_o} = {p, 2'b11};
    @(negedge clk_i) {v[15:8], rf_o} = {rd_data_i, 1'b0};
    @(negedge clk_i) {v[7:0], rd_o} = {rd_data_i, 1'b0};
  endtask : rd16
endmodule : ltl_host

// File: sim/ltl_regs_properties.sv
// ltl_regs_chk: port-level properties of the threshold register bank
// assumes one clock domain, synchronous active-low reset
`timescale 1ns/1ps
module ltl_regs_chk
  import ltl_pkg::*;
(
  input wire logic clk_i, reset_n_i, wr_byte_i, wr_first_i, rd_byte_i, rd_first_i,
  input wire logic [7:0] reg_ptr_i, wr_data_i, rd_data_o,
  input wire logic result_valid_i, flag_clear_i, over_flag_o, under_flag_o, alert_o,
  input wire logic [REG_W-1:0] result_raw_i, lower_o, upper_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  function automatic logic [22:0] pw(input logic [15:0] w);
    return {11'h0, w[11:0]} << ((w[15:12] > 4'hB) ? 4'hB : w[15:12]);
  endfunction : pw
  property p_alert; alert_o == (over_flag_o | under_flag_o); endproperty
  a_alert: assert property (p_alert) else $error("alert differs from flags");
  property p_lower_wr;
    wr_byte_i && !wr_first_i && reg_ptr_i == ADDR_LOWER |=> lower_o[7:0] == $past(wr_data_i);
  endproperty
  a_lower_wr: assert property (p_lower_wr) else $error("lower lsb not stored");
  property p_rst; $rose(reset_n_i) |-> lower_o == LOWER_RESET && upper_o == UPPER_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("threshold reset value wrong");
  property p_maker; rd_byte_i && rd_first_i && reg_ptr_i == ADDR_MAKER |=>
    rd_data_o == MAKER_CODE[15:8]; endproperty
  a_maker: assert property (p_maker) else $error("maker code msb wrong");
  property p_rdmsb; rd_byte_i && rd_first_i && reg_ptr_i == ADDR_UPPER |=>
    rd_data_o == $past(upper_o[15:8]); endproperty
  a_rdmsb: assert property (p_rdmsb) else $error("msb byte not first");
  property p_over; $rose(over_flag_o) |-> $past(result_valid_i) &&
    pw($past(result_raw_i)) > pw($past(upper_o)); endproperty
  a_over: assert property (p_over) else $error("over flag without cause");
  property p_under; $rose(under_flag_o) |-> $past(result_valid_i) &&
    pw($past(result_raw_i)) < pw($past(lower_o)); endproperty
  a_under: assert property (p_under) else $error("under flag without cause");
  property p_clr; flag_clear_i && !result_valid_i |=> !over_flag_o && !under_flag_o;
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");
  c_over: cover property ($rose(over_flag_o));
  c_under: cover property ($rose(under_flag_o));
  c_maker: cover property (rd_byte_i && reg_ptr_i == ADDR_MAKER);
endmodule : ltl_regs_chk
bind ltl_regs ltl_regs_chk u_ltl_regs_chk (.*);

// File: sim/tb.sv
// tb: register and measurement sequences for ltl_regs
// assumes ltl_host as register partner, 20 MHz clock
`timescale 1ns/1ps
module tb;
  import ltl_pkg::*;
  logic clk_i = 0, reset_n_i = 0, wr_byte_i, wr_first_i, rd_byte_i, rd_first_i;
  logic result_valid_i = 0, flag_clear_i = 0, over_flag_o, under_flag_o, alert_o;
  logic [7:0] reg_ptr_i, wr_data_i, rd_data_o;
  logic [1:0] fault_count_i = 0;
  logic [15:0] result_raw_i = 0, lower_o, upper_o, v;
  int n_errors = 0, n_checks = 0, cyc = 0;
  ltl_regs u_ltl_regs (.*);
  ltl_host u_ltl_host (.clk_i(clk_i), .ptr_o(reg_ptr_i), .wr_o(wr_byte_i), .wf_o(wr_first_i),
    .wd_o(wr_data_i), .rd_o(rd_byte_i), .rf_o(rd_first_i), .rd_data_i(rd_data_o));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc > 3000) begin
    n_errors++;
    end_of_test();
  end
  task automatic chk(input string s, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic chk_flags(input string s, input logic [2:0] e);
    n_checks++;
    if ({alert_o, over_flag_o, under_flag_o} !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, e, {alert_o, over_flag_o, under_flag_o});
    end
  endtask : chk_flags
  task automatic meas(input logic [15:0] r);
    @(negedge clk_i) {result_valid_i, result_raw_i} = {1'b1, r};
    @(negedge clk_i) {result_valid_i, result_raw_i} = {1'b0, ~r};
  endtask : meas
  task automatic clr();
    @(negedge clk_i) flag_clear_i = 1;
    @(negedge clk_i) flag_clear_i = 0;
  endtask : clr
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (6) @(negedge clk_i);
    reset_n_i = 1;
    u_ltl_host.rd16(ADDR_LOWER, v);
    chk("lower reset", LOWER_RESET, v);
    u_ltl_host.rd16(ADDR_UPPER, v);
    chk("upper reset", 16'hBFFF, v);
    u_ltl_host.wr16(ADDR_MAKER, 16'h1234);
    u_ltl_host.rd16(ADDR_MAKER, v);
    chk("maker", MAKER_CODE, v);
    u_ltl_host.rd16(8'h55, v);
    chk("unmapped", 16'h0000, v);
    u_ltl_host.wr16(ADDR_LOWER, 16'hA5C3);
    u_ltl_host.wr16(ADDR_UPPER, 16'h5A3C);
    u_ltl_host.rd16(ADDR_LOWER, v);
    chk("lower", 16'hA5C3, v);
    u_ltl_host.rd16(ADDR_UPPER, v);
    chk("upper", 16'h5A3C, v);
    $display("test registers done");
    // upper power 200h; results cross it with a different exponent
    u_ltl_host.wr16(ADDR_LOWER, 16'h0000);
    u_ltl_host.wr16(ADDR_UPPER, 16'h1100);
    for (int fc = 0; fc < 4; fc++) begin
      fault_count_i = 2'(fc);
      clr();
      meas(16'h2080);
      repeat ((1 << fc) - 1) meas(16'h0201);
      chk_flags("flags early", 3'h0);
      meas(16'h0201);
      chk_flags("flags over", 3'h6);
    end
    $display("test over done");
    u_ltl_host.wr16(ADDR_LOWER, 16'h3010);
    fault_count_i = FC_TWO;
    clr();
    meas(16'h007F);
    meas(16'h0100);
    meas(16'h007F);
    chk_flags("flags reset run", 3'h0);
    meas(16'h007F);
    chk_flags("flags under", 3'h5);
    clr();
    chk_flags("flags clear", 3'h0);
    $display("test under done");
    // codes above Bh act as Bh; an unsaturated F7FFh would wrap above B800h
    u_ltl_host.wr16(ADDR_UPPER, 16'hB800);
    fault_count_i = FC_ONE;
    meas(16'hF7FF);
    chk_flags("flags top code", 3'h0);
    meas(16'hF801);
    chk_flags("flags top over", 3'h6);
    $display("test range done");
    reset_n_i = 0;
    repeat (6) @(negedge clk_i);
    reset_n_i = 1;
    chk_flags("flags after reset", 3'h0);
    u_ltl_host.rd16(ADDR_LOWER, v);
    chk("lower after reset", LOWER_RESET, v);
    u_ltl_host.rd16(ADDR_UPPER, v);
    chk("upper after reset", UPPER_RESET, v);
    $display("test reset done");
    end_of_test();
  end
endmodule : tb
